// ### timer_defines.vh
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH

// ==========================================
// Register byte offsets
`define OFS_CTRL0 8'h00
`define OFS_VAL0 8'h04
`define OFS_CTRL1 8'h08
`define OFS_LOW1 8'h0C
`define OFS_HIGH1 8'h10
`define OFS_CTRL2 8'h14
`define OFS_VAL2 8'h18
`define OFS_CTRL3 8'h1C
`define OFS_VAL3 8'h20

// ==========================================
// Control fields
`define MODE_HI 7
`define MODE_LO 6
`define CLK_SEL_BIT 5
`define RUN_BIT 4
`define EDGE_BIT 3
`define PSC_HI 2
`define CTRL_RESET 8'h08
`define NARROW_CTRL_MASK 8'hDF
`define WIDE_CTRL_MASK 8'hF8

// ==========================================
// Mode codes
`define MODE_NONE 2'h0
`define MODE_EVENT 2'h1
`define MODE_TIMER 2'h2
`define MODE_PULSE 2'h3

// ==========================================
// Timing
`define WIDE_SYS_DIV_MASK 7'h03

`endif

// ### timer_event_counter.v
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "timer_defines.vh"

module timer_event_counter #(
    parameter WIDE_SUB_OPTION = 1
) (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [3:0] timer_pin,
    input wire subsidiary_clock,
    output reg [3:0] overflow
);

// ==========================================
// Decode helpers
function [3:0] narrow_index;
    input [7:0] ofs;
    begin
        case (ofs)
            `OFS_CTRL0,
            `OFS_VAL0: narrow_index = 4'h0;
            `OFS_CTRL2,
            `OFS_VAL2: narrow_index = 4'h1;
            `OFS_CTRL3,
            `OFS_VAL3: narrow_index = 4'h2;
            default: narrow_index = 4'hF;
        endcase
    end
endfunction

function is_mapped;
    input [31:0] addr;
    begin
        case (addr[7:0])
            `OFS_CTRL0,
            `OFS_VAL0,
            `OFS_CTRL1,
            `OFS_LOW1,
            `OFS_HIGH1,
            `OFS_CTRL2,
            `OFS_VAL2,
            `OFS_CTRL3,
            `OFS_VAL3:
                is_mapped = (addr[31:8] == 24'h000000);
            default: is_mapped = 1'b0;
        endcase
    end
endfunction

function is_value;
    input [7:0] ofs;
    begin
        case (ofs)
            `OFS_VAL0,
            `OFS_VAL2,
            `OFS_VAL3: is_value = 1'b1;
            default: is_value = 1'b0;
        endcase
    end
endfunction

function [1:0] pin_of;
    input integer idx;
    begin
        case (idx)
            0: pin_of = 2'd0;
            1: pin_of = 2'd2;
            default: pin_of = 2'd3;
        endcase
    end
endfunction

function psc_tick;
    input [6:0] cnt;
    input [2:0] code;
    reg [7:0] mask;
    begin
        mask = (8'h01 << code) - 8'h01;
        psc_tick = ((cnt & mask[6:0]) == mask[6:0]);
    end
endfunction

function step_ok;
    input [7:0] ctrl;
    input tick;
    input rise;
    input fall;
    input level;
    begin
        if (!ctrl[`RUN_BIT]) begin
            step_ok = 1'b0;
        end else begin
            case (ctrl[`MODE_HI:`MODE_LO])
                `MODE_EVENT:
                    step_ok = ctrl[`EDGE_BIT] ? fall : rise;
                `MODE_TIMER:
                    step_ok = tick;
                `MODE_PULSE:
                    step_ok = tick & (level == ctrl[`EDGE_BIT]);
                default:
                    step_ok = 1'b0;
            endcase
        end
    end
endfunction

// ==========================================
// Bus phases
wire setup_phase;
wire access_phase;
wire wr_stb;
wire rd_stb;
wire [7:0] ofs;
wire [7:0] wbyte;

assign setup_phase = psel & ~penable;
assign access_phase = psel & penable;
assign pready = 1'b1;
assign pslverr = access_phase & ~is_mapped(paddr);
assign wr_stb = access_phase & pwrite & is_mapped(paddr);
assign rd_stb = access_phase & ~pwrite & is_mapped(paddr);
assign ofs = paddr[7:0];
assign wbyte = pwdata[7:0];

// ==========================================
// Pin and subsidiary clock synchronisers
reg [3:0] pin_meta_reg;
reg [3:0] pin_sync_reg;
reg [3:0] pin_prev_reg;
reg sub_meta_reg;
reg sub_sync_reg;
reg sub_prev_reg;
wire [3:0] pin_rise;
wire [3:0] pin_fall;
wire sub_rise;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        pin_meta_reg <= 4'h0;
        pin_sync_reg <= 4'h0;
        pin_prev_reg <= 4'h0;
        sub_meta_reg <= 1'b0;
        sub_sync_reg <= 1'b0;
        sub_prev_reg <= 1'b0;
    end else begin
        pin_meta_reg <= timer_pin;
        pin_sync_reg <= pin_meta_reg;
        pin_prev_reg <= pin_sync_reg;
        sub_meta_reg <= subsidiary_clock;
        sub_sync_reg <= sub_meta_reg;
        sub_prev_reg <= sub_sync_reg;
    end
end

assign pin_rise = pin_sync_reg & ~pin_prev_reg;
assign pin_fall = ~pin_sync_reg & pin_prev_reg;
assign sub_rise = sub_sync_reg & ~sub_prev_reg;

// ==========================================
// Shared prescaler
reg [6:0] psc_reg;
wire [6:0] psc_next;

assign psc_next = psc_reg + 7'h01;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        psc_reg <= 7'h00;
    end else begin
        psc_reg <= psc_next;
    end
end

// ==========================================
// Wide system clock tick
wire wide_sys_tick;

assign wide_sys_tick = ((psc_reg & `WIDE_SYS_DIV_MASK) == `WIDE_SYS_DIV_MASK);

// ==========================================
// Narrow counters (pins 0, 2, 3)
wire [7:0] narrow_ctrl [0:2];
wire [7:0] narrow_count [0:2];
wire [2:0] narrow_ovf;

genvar g;
generate
    for (g = 0; g < 3; g = g + 1) begin : narrow
        localparam [1:0] PIN = pin_of(g);
        reg [7:0] ctrl_reg;
        reg [7:0] count_reg;
        reg [7:0] preload_reg;
        wire sel;
        wire tick;
        wire step;
        wire ctrl_wr;
        wire value_wr;

        assign sel = (narrow_index(ofs) == g);
        assign ctrl_wr = wr_stb & sel & ~is_value(ofs);
        assign value_wr = wr_stb & sel & is_value(ofs);
        assign tick = psc_tick(psc_reg, ctrl_reg[`PSC_HI:0]);
        assign step = step_ok(ctrl_reg, tick, pin_rise[PIN],
                              pin_fall[PIN], pin_sync_reg[PIN]);

        always @(posedge clk or posedge rst) begin
            if (rst) begin
                ctrl_reg <= `CTRL_RESET;
            end else if (ctrl_wr) begin
                ctrl_reg <= wbyte & `NARROW_CTRL_MASK;
            end
        end

        // Preload holds no reset value
        always @(posedge clk) begin
            if (value_wr) begin
                preload_reg <= wbyte;
            end
        end

        always @(posedge clk or posedge rst) begin
            if (rst) begin
                count_reg <= 8'h00;
            end else if (value_wr && !ctrl_reg[`RUN_BIT]) begin
                count_reg <= wbyte;
            end else if (step) begin
                if (count_reg == 8'hFF) begin
                    count_reg <= preload_reg;
                end else begin
                    count_reg <= count_reg + 8'h01;
                end
            end
        end

        assign narrow_ctrl[g] = ctrl_reg;
        assign narrow_count[g] = count_reg;
        assign narrow_ovf[g] = step & (count_reg == 8'hFF);
    end
endgenerate

// ==========================================
// Wide counter (pin 1)
reg [7:0] wide_ctrl_reg;
reg [15:0] wide_count_reg;
reg [15:0] wide_preload_reg;
reg [7:0] low_buffer_reg;
reg [7:0] low_latch_reg;
wire wide_tick;
wire wide_step;
wire wide_ovf;
wire [15:0] wide_load;
wire ctrl_wide_wr;
wire low_wr;
wire high_wr;
wire high_rd;

// ==========================================
// Wide register strobes
assign ctrl_wide_wr = wr_stb & (ofs == `OFS_CTRL1);
assign low_wr = wr_stb & (ofs == `OFS_LOW1);
assign high_wr = wr_stb & (ofs == `OFS_HIGH1);
assign high_rd = rd_stb & (ofs == `OFS_HIGH1);

// ==========================================
// Wide counter stepping
assign wide_tick = (WIDE_SUB_OPTION != 0 && wide_ctrl_reg[`CLK_SEL_BIT])
    ? sub_rise
    : wide_sys_tick;
assign wide_step = step_ok(wide_ctrl_reg, wide_tick, pin_rise[1],
                           pin_fall[1], pin_sync_reg[1]);
assign wide_ovf = wide_step & (wide_count_reg == 16'hFFFF);
assign wide_load = {wbyte, low_buffer_reg};

always @(posedge clk or posedge rst) begin
    if (rst) begin
        wide_ctrl_reg <= `CTRL_RESET;
    end else if (ctrl_wide_wr) begin
        wide_ctrl_reg <= wbyte & `WIDE_CTRL_MASK;
    end
end

// Preload and low buffer hold no reset value
always @(posedge clk) begin
    if (low_wr) begin
        low_buffer_reg <= wbyte;
    end
    if (high_wr) begin
        wide_preload_reg <= wide_load;
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        wide_count_reg <= 16'h0000;
    end else if (high_wr && !wide_ctrl_reg[`RUN_BIT]) begin
        wide_count_reg <= wide_load;
    end else if (wide_step) begin
        if (wide_count_reg == 16'hFFFF) begin
            wide_count_reg <= wide_preload_reg;
        end else begin
            wide_count_reg <= wide_count_reg + 16'h0001;
        end
    end
end

// High byte read latches the live low byte
always @(posedge clk or posedge rst) begin
    if (rst) begin
        low_latch_reg <= 8'h00;
    end else if (high_rd) begin
        low_latch_reg <= wide_count_reg[7:0];
    end
end

// ==========================================
// Overflow requests
wire [3:0] ovf_all;

assign ovf_all[0] = narrow_ovf[0];
assign ovf_all[1] = wide_ovf;
assign ovf_all[2] = narrow_ovf[1];
assign ovf_all[3] = narrow_ovf[2];

always @(posedge clk or posedge rst) begin
    if (rst) begin
        overflow <= 4'h0;
    end else begin
        overflow <= ovf_all;
    end
end

// ==========================================
// Read data, captured in the setup cycle
reg [7:0] rd_byte;

always @* begin
    case (ofs)
        `OFS_CTRL0: rd_byte = narrow_ctrl[0];
        `OFS_VAL0: rd_byte = narrow_count[0];
        `OFS_CTRL1: rd_byte = wide_ctrl_reg;
        `OFS_LOW1: rd_byte = low_latch_reg;
        `OFS_HIGH1: rd_byte = wide_count_reg[15:8];
        `OFS_CTRL2: rd_byte = narrow_ctrl[1];
        `OFS_VAL2: rd_byte = narrow_count[1];
        `OFS_CTRL3: rd_byte = narrow_ctrl[2];
        `OFS_VAL3: rd_byte = narrow_count[2];
        default: rd_byte = 8'h00;
    endcase
end

// ==========================================
// Read word
wire [31:0] rd_word;

assign rd_word = is_mapped(paddr) ? {24'h000000, rd_byte} : 32'h00000000;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
        prdata <= rd_word;
    end
end

endmodule
`default_nettype wire

// ### timer_event_counter_properties.sv
`timescale 1ns/10ps
`default_nettype none
module timer_event_counter_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] overflow
);
    // ==========================================
    // Shadow of run bits and first control word
    logic acc;
    logic [3:0] run_q, run_q2, run_q3;
    logic [7:0] ctrl0_sh;
    assign acc = psel && penable;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_q <= 4'h0;
            ctrl0_sh <= 8'h08;
        end else if (acc && pwrite) begin
            if (paddr == 32'h00) begin
                run_q[0] <= pwdata[4];
                ctrl0_sh <= pwdata[7:0];
            end
            if (paddr == 32'h08) run_q[1] <= pwdata[4];
            if (paddr == 32'h14) run_q[2] <= pwdata[4];
            if (paddr == 32'h1C) run_q[3] <= pwdata[4];
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_q2 <= 4'h0;
            run_q3 <= 4'h0;
        end else begin
            run_q2 <= run_q;
            run_q3 <= run_q2;
        end
    end
    // ==========================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    pready_tied_a: assert property (pready)
        else $error("pready low");
    err_unmapped_a: assert property (acc && paddr > 32'h20 |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    err_mapped_a: assert property (acc && paddr <= 32'h20 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    err_idle_a: assert property (!acc |-> !pslverr)
        else $error("pslverr outside access");
    rdata_upper_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    rdata_held_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved in access");
    ctrl_readback_a: assert property (acc && !pwrite && paddr == 32'h0 |-> prdata[7:0] == (ctrl0_sh & 8'hDF))
        else $error("control readback wrong");
    stopped_quiet_a: assert property ((overflow & ~(run_q | run_q2 | run_q3)) == 4'h0)
        else $error("overflow from stopped counter");
    cover property (overflow[0]);
    cover property (overflow[1]);
    cover property (acc && pslverr);
endmodule
bind timer_event_counter timer_event_counter_properties u_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .overflow(overflow));
`default_nettype wire

// ### pin_source.sv
`timescale 1ns/10ps
`default_nettype none
module pin_source (
    input wire logic clk,
    output logic [3:0] pins,
    output logic sub_clk
);
    initial begin
        pins = 4'h0;
        sub_clk = 1'b0;
    end
    // Slow clock, twenty system cycles a period
    always begin
        repeat (10) @(posedge clk);
        sub_clk <= ~sub_clk;
    end
    // One edge per step, held gap plus one cycles
    task automatic flip(input int idx, input int n, input int gap);
        repeat (n) begin
            @(posedge clk);
            pins[idx] <= ~pins[idx];
            repeat (gap) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ### test_timer_event_counter.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer_defines.vh"
module test_timer_event_counter;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, sub_clk, err;
    logic [3:0] pins, overflow;
    int miscompares = 0;
    int samples_checked = 0;
    int cyc = 0;
    int ov_idx = 0;
    int t_ov[$];
    always #10 clk = ~clk;
    timer_event_counter u_timer_event_counter (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_pin(pins), .subsidiary_clock(sub_clk), .overflow(overflow));
    pin_source u_pin_source (.clk(clk), .pins(pins), .sub_clk(sub_clk));
    // ==========================================
    // Overflow stamps and timeout
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (overflow[ov_idx] === 1'b1) t_ov.push_back(cyc);
        if (cyc > 20000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // ==========================================
    // APB transfers
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rc(input logic [31:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    // Overflow spacing of a running counter
    task automatic period(input int idx, input logic [31:0] ca, input logic [7:0] cv, input int e);
        ov_idx = idx;
        wr(ca, {24'h0, cv});
        t_ov.delete();
        while (t_ov.size() < 3) @(posedge clk);
        check(t_ov[2] - t_ov[1], e);
        wr(ca, 32'h0);
    endtask
    // ==========================================
    // Sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rc(`OFS_CTRL0, 32'h08);
        rc(`OFS_CTRL1, 32'h08);
        apb(1'b0, 32'h24, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        wr(`OFS_CTRL0, 32'hFF);
        rc(`OFS_CTRL0, 32'hDF);
        wr(`OFS_CTRL1, 32'hFF);
        rc(`OFS_CTRL1, 32'hF8);
        wr(`OFS_CTRL0, 32'h00);
        wr(`OFS_CTRL1, 32'h00);
        wr(`OFS_VAL0, 32'h5A);
        rc(`OFS_VAL0, 32'h5A);
        wr(`OFS_CTRL0, 32'h40);
        u_pin_source.flip(0, 4, 4);
        rc(`OFS_VAL0, 32'h5A);
        wr(`OFS_CTRL0, 32'h50);
        u_pin_source.flip(0, 6, 4);
        rc(`OFS_VAL0, 32'h5D);
        wr(`OFS_CTRL0, 32'h5F);
        u_pin_source.flip(0, 6, 4);
        rc(`OFS_VAL0, 32'h60);
        wr(`OFS_CTRL0, 32'h10);
        u_pin_source.flip(0, 4, 4);
        rc(`OFS_VAL0, 32'h60);
        wr(`OFS_CTRL0, 32'h00);
        wr(`OFS_VAL0, 32'hFE);
        wr(`OFS_CTRL0, 32'h50);
        wr(`OFS_VAL0, 32'hF0);
        rc(`OFS_VAL0, 32'hFE);
        t_ov.delete();
        u_pin_source.flip(0, 4, 4);
        rc(`OFS_VAL0, 32'hF0);
        check(t_ov.size(), 1);
        wr(`OFS_CTRL0, 32'h00);
        wr(`OFS_VAL2, 32'hFC);
        for (int c = 0; c < 8; c++) period(2, `OFS_CTRL2, 8'h90 | 8'(c), 4 << c);
        wr(`OFS_LOW1, 32'hFC);
        wr(`OFS_HIGH1, 32'hFF);
        rc(`OFS_HIGH1, 32'hFF);
        rc(`OFS_LOW1, 32'hFC);
        wr(`OFS_LOW1, 32'h33);
        rc(`OFS_HIGH1, 32'hFF);
        rc(`OFS_LOW1, 32'hFC);
        wr(`OFS_LOW1, 32'hFC);
        wr(`OFS_HIGH1, 32'hFF);
        period(1, `OFS_CTRL1, 8'h90, 16);
        period(1, `OFS_CTRL1, 8'hB0, 80);
        u_pin_source.flip(3, 1, 4);
        wr(`OFS_VAL3, 32'h00);
        wr(`OFS_CTRL3, 32'hD0);
        repeat (20) @(posedge clk);
        rc(`OFS_VAL3, 32'h00);
        rc(`OFS_CTRL3, 32'hD0);
        u_pin_source.flip(3, 1, 40);
        u_pin_source.flip(3, 1, 4);
        rc(`OFS_VAL3, 32'h29);
        wr(`OFS_CTRL3, 32'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
